/* File: hdl/gcfg_pkg.sv */
package gcfg_pkg;

    // Number of configurable pins handled by the block.
    localparam int NPIN = 3;

    // Printed register indices; byte address is four times the index.
    localparam logic [NPIN*8-1:0] PIN_IDX = {8'h45, 8'h44, 8'h43};
    localparam logic [1:0] PIN_NONE = 2'h3;

    // Field positions inside each pin configuration byte.
    localparam int BIT_SLEEP = 7;
    localparam int BIT_SEL = 6;
    localparam int BIT_ODEN = 5;
    localparam int BIT_DEB = 4;
    localparam int BIT_PDEN = 3;
    localparam int BIT_DIR = 2;
    localparam int BIT_LVL = 1;
    localparam int BIT_SET = 0;

    // Writable bits; the pad level bit is never stored.
    localparam logic [7:0] WR_MASK = 8'hfd;
    localparam logic [7:0] CFG_RST = 8'h00;

    // Debounce times in ns, rounded up to whole clock cycles.
    localparam int CLK_PERIOD_NS = 40;
    localparam int DEB_SHORT_NS = 94000;
    localparam int DEB_LONG_NS = 156000;
    localparam logic [11:0] DEB_SHORT_CYC = 12'((DEB_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [11:0] DEB_LONG_CYC = 12'((DEB_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // Bus responses.
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Start-up states: load defaults once, then run.
    typedef enum logic {
        ST_LOAD = 1'b0,
        ST_RUN = 1'b1
    } gcfg_state_t;

endpackage : gcfg_pkg

/* File: hdl/gcfg_debounce.sv */
`timescale 1ns/1ps
`default_nettype none
module gcfg_debounce
    import gcfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic pad_raw,
    input wire logic long_sel,
    output logic level
);
    logic s1_reg;
    logic s2_reg;
    logic ok_reg;
    logic [11:0] cnt_reg;
    logic lvl_reg;
    wire logic [11:0] lim = long_sel ? DEB_LONG_CYC : DEB_SHORT_CYC;
    wire logic mism = !ok_reg || (s2_reg != lvl_reg);
    wire logic done = mism && (cnt_reg >= lim - 12'h001);

    // Synchroniser and stability counter; once the level has first settled, a bounce restarts the count.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            ok_reg <= 1'b0;
            cnt_reg <= 12'h000;
        end else begin
            s1_reg <= pad_raw;
            s2_reg <= s1_reg;
            ok_reg <= ok_reg | done;
            cnt_reg <= (mism && !done) ? cnt_reg + 12'h001 : 12'h000;
        end
    end

    // The level has no reset value; it settles one debounce time after reset.
    always_ff @(posedge core_clk) begin
        if (done) begin
            lvl_reg <= s2_reg;
        end
    end

    assign level = lvl_reg;

    AST_DEB_TAKE: assert property (@(posedge core_clk) disable iff (!rstn)
        done |=> lvl_reg == $past(s2_reg)) else $error("Debounced level not taken.");
    AST_DEB_HOLD: assert property (@(posedge core_clk) disable iff (!rstn)
        ok_reg && !done |=> lvl_reg == $past(lvl_reg)) else $error("Level moved early.");
endmodule : gcfg_debounce
`default_nettype wire

/* File: hdl/gcfg_pad_drive.sv */
`timescale 1ns/1ps
`default_nettype none
module gcfg_pad_drive
    import gcfg_pkg::*;
(
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [7:0] cfg,
    input wire logic sleep_state,
    input wire logic led,
    output logic pad_out,
    output logic pad_oe_n,
    output logic pad_pulldown,
    output logic pad_seq_assigned
);
    logic out_reg;
    logic oe_n_reg;
    logic pd_reg;
    logic seq_reg;
    wire logic dir = cfg[BIT_DIR];
    wire logic od = cfg[BIT_ODEN];
    wire logic force_lo = sleep_state && cfg[BIT_SLEEP];
    wire logic src = cfg[BIT_SEL] ? led : cfg[BIT_SET];
    wire logic val = src && !force_lo;

    // Open drain only sinks, so it releases the pad for a high level.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            out_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            pd_reg <= 1'b0;
            seq_reg <= 1'b0;
        end else begin
            out_reg <= dir && !od && val;
            oe_n_reg <= !dir || (od && val);
            pd_reg <= cfg[BIT_PDEN];
            seq_reg <= dir && !od;
        end
    end

    assign pad_out = out_reg;
    assign pad_oe_n = oe_n_reg;
    assign pad_pulldown = pd_reg;
    assign pad_seq_assigned = seq_reg;

    sequence s_sleep_out;
        force_lo && dir;
    endsequence
    AST_SLEEP_LOW: assert property (@(posedge core_clk) disable iff (!rstn)
        s_sleep_out |=> !pad_oe_n && !pad_out) else $error("Sleep did not force low.");
    AST_IN_RELEASE: assert property (@(posedge core_clk) disable iff (!rstn)
        !dir |=> pad_oe_n) else $error("Input pad driven.");
    AST_OD_NO_HIGH: assert property (@(posedge core_clk) disable iff (!rstn)
        dir && od |=> !pad_out) else $error("Open drain drove high.");
    AST_PP_SET: assert property (@(posedge core_clk) disable iff (!rstn)
        dir && !od && !cfg[BIT_SEL] && !force_lo |=> !pad_oe_n && pad_out == $past(cfg[BIT_SET]))
        else $error("Software value not driven.");
endmodule : gcfg_pad_drive
`default_nettype wire

/* File: hdl/gcfg_top.sv */
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Sleep plus force bit drives output low.
// - Source bit clear drives software value out.
// - Third pin can carry first LED driver.
// - Fourth pin can carry second LED driver.
// - Drive bit clear: push-pull, sequence assigned when direction set.
// - Drive bit set: open drain, sink only.
// - Debounce 94 us or 156 us.
// - Pulldown follows its enable bit.
// - Direction clear: pad is undriven input.
// - Direction set: output, joins power-up sequence only when push-pull.
// - Pad level bit shows pad, no reset.
// - Software value one drives one in push-pull and releases in open drain; zero drives zero.
// - Power-on reset resets every configuration register.
// - Fourth and fifth pins at 44h, 45h.
// - Writable defaults come from one-time memory.
module gcfg_top
    import gcfg_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [NPIN*8-1:0] otp_default,
    input wire logic sleep_state,
    input wire logic led_driver_first,
    input wire logic led_driver_second,
    input wire logic led_driver_third,
    input wire logic [NPIN-1:0] pad_in,
    output logic [NPIN-1:0] pad_out,
    output logic [NPIN-1:0] pad_oe_n,
    output logic [NPIN-1:0] pad_pulldown,
    output logic [NPIN-1:0] pad_seq_assigned
);

    // Maps a byte address onto a pin slot, or PIN_NONE.
    function automatic logic [1:0] addr_to_pin(input logic [ADDR_W-1:0] a);
        logic [1:0] p;
        p = PIN_NONE;
        for (int i = 0; i < NPIN; i++) begin
            if (a == ADDR_W'({PIN_IDX[i*8 +: 8], 2'b00})) begin
                p = 2'(i);
            end
        end
        return p;
    endfunction : addr_to_pin

    gcfg_state_t state_reg;
    gcfg_state_t state_next;
    logic [NPIN-1:0][7:0] cfg_reg;
    logic [NPIN-1:0][7:0] cfg_next;
    logic [NPIN-1:0][7:0] view;
    logic [NPIN-1:0] lvl;

    logic aw_hold_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic w_hold_reg;
    logic [7:0] wdata_reg;
    logic wstrb0_reg;
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;

    // LED sources per pin; the fifth pin takes the third driver.
    wire logic [NPIN-1:0] led_src = {led_driver_third, led_driver_second, led_driver_first};

    // Start-up: one cycle after reset release the defaults are loaded.
    wire logic loading = (state_reg == ST_LOAD);
    assign state_next = ST_RUN;

    // Handshake terms of the write path.
    wire logic aw_take = s_axi_awvalid && awready_reg;
    wire logic w_take = s_axi_wvalid && wready_reg;
    wire logic do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire logic [1:0] wr_pin = addr_to_pin(awaddr_reg);
    wire logic wr_hit = (wr_pin != PIN_NONE);
    wire logic aw_hold_next = (aw_hold_reg || aw_take) && !do_write;
    wire logic w_hold_next = (w_hold_reg || w_take) && !do_write;
    wire logic bvalid_next = do_write || (bvalid_reg && !s_axi_bready);

    // Handshake terms of the read path.
    wire logic ar_take = s_axi_arvalid && arready_reg;
    wire logic rvalid_next = ar_take || (rvalid_reg && !s_axi_rready);
    wire logic [1:0] rd_pin = addr_to_pin(s_axi_araddr);
    wire logic rd_hit = (rd_pin != PIN_NONE);
    wire logic [7:0] rd_byte = rd_hit ? view[rd_pin] : 8'h00;

    // OTP defaults masked so the level bit never lands in storage.
    wire logic [NPIN*8-1:0] otp_m = otp_default & {NPIN{WR_MASK}};

    // Next configuration and the read view with the live level merged in.
    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_pin
            wire logic hit = do_write && wr_hit && (wr_pin == 2'(gi)) && wstrb0_reg;
            assign cfg_next[gi] = loading ? otp_m[gi*8 +: 8]
                : hit ? (wdata_reg & WR_MASK)
                : cfg_reg[gi];
            assign view[gi] = cfg_reg[gi] | ({7'h00, lvl[gi]} << BIT_LVL);

            gcfg_debounce u_deb (
                .core_clk(core_clk),
                .rstn(rstn),
                .pad_raw(pad_in[gi]),
                .long_sel(cfg_reg[gi][BIT_DEB]),
                .level(lvl[gi])
            );

            gcfg_pad_drive u_drv (
                .core_clk(core_clk),
                .rstn(rstn),
                .cfg(cfg_reg[gi]),
                .sleep_state(sleep_state),
                .led(led_src[gi]),
                .pad_out(pad_out[gi]),
                .pad_oe_n(pad_oe_n[gi]),
                .pad_pulldown(pad_pulldown[gi]),
                .pad_seq_assigned(pad_seq_assigned[gi])
            );
        end
    endgenerate

    // Configuration storage; the async reset gives a constant, the OTP
    // value follows on the first edge after release.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ST_LOAD;
            cfg_reg <= {NPIN{CFG_RST}};
        end else begin
            state_reg <= state_next;
            cfg_reg <= cfg_next;
        end
    end

    // Write address and data are taken in either order and held until
    // both are present; readies stay low while a response is pending.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awready_reg <= 1'b0;
            wready_reg <= 1'b0;
            bvalid_reg <= 1'b0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            awready_reg <= !aw_hold_next && !bvalid_next;
            wready_reg <= !w_hold_next && !bvalid_next;
            bvalid_reg <= bvalid_next;
        end
    end

    // Write payload and response code.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            awaddr_reg <= '0;
            wdata_reg <= 8'h00;
            wstrb0_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata[7:0];
                wstrb0_reg <= s_axi_wstrb[0];
            end
            if (do_write) begin
                bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Read path answers one cycle after the address is taken.
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else begin
            arready_reg <= !rvalid_next;
            rvalid_reg <= rvalid_next;
            if (ar_take) begin
                rdata_reg <= {24'h00_0000, rd_byte};
                rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    // Bus outputs come straight from their flip-flops.
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;

    // Checks on start-up loading, register writes and bus timing.
    sequence s_both_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence

    sequence s_write_pin4;
        do_write && wr_pin == 2'h1 && wstrb0_reg;
    endsequence

    AST_LOAD_OTP: assert property (@(posedge core_clk) disable iff (!rstn)
        loading |=> cfg_reg == $past(otp_m)) else $error("Defaults not loaded.");
    AST_WR_PIN4: assert property (@(posedge core_clk) disable iff (!rstn)
        s_write_pin4 |=> cfg_reg[1] == ($past(wdata_reg) & WR_MASK))
        else $error("Pin four write lost.");
    AST_LVL_NOT_STORED: assert property (@(posedge core_clk) disable iff (!rstn)
        (cfg_reg & ~{NPIN{WR_MASK}}) == '0) else $error("Level bit stored.");
    AST_BRESP_TIME: assert property (@(posedge core_clk) disable iff (!rstn)
        s_both_taken |-> ##2 s_axi_bvalid) else $error("Write response late.");
    AST_RD_TIME: assert property (@(posedge core_clk) disable iff (!rstn)
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h00_0000)
        else $error("Read answer wrong.");

endmodule : gcfg_top
`default_nettype wire

/* File: testbench/gcfg_board.sv */
`timescale 1ns/1ps
`default_nettype none
// Board wiring of the three pins: a pull-up resistor and an optional external driver.
module gcfg_board
    import gcfg_pkg::*;
(
    input wire logic [NPIN-1:0] pad_out,
    input wire logic [NPIN-1:0] pad_oe_n,
    input wire logic [NPIN-1:0] pad_pulldown,
    input wire logic [NPIN-1:0] ext_en,
    input wire logic [NPIN-1:0] ext_val,
    output logic [NPIN-1:0] pad_in
);
    // The device wins, then the external driver; the pulldown beats the weak board pull-up.
    // A released pin never keeps its last value, it goes to the resistor's level.
    assign pad_in = (~pad_oe_n & pad_out) | (pad_oe_n & ext_en & ext_val)
        | (pad_oe_n & ~ext_en & ~pad_pulldown);
endmodule : gcfg_board
`default_nettype wire

/* File: testbench/pmic_gpio_pin_config_test.sv */
`timescale 1ns/1ps
`default_nettype none
module pmic_gpio_pin_config_test
    import gcfg_pkg::*;
;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000;
    logic [11:0] s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, sleep_state = 1'b0;
    logic led_driver_first = 1'b0, led_driver_second = 1'b0, led_driver_third = 1'b0;
    logic [NPIN*8-1:0] otp_default = 24'h128f00;
    logic [2:0] ext_en = 3'h0, ext_val = 3'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    logic [2:0] pad_in, pad_out, pad_oe_n, pad_pulldown, pad_seq_assigned;
    int num_errors = 0;
    int total_checks = 0;
    // Pin, config byte, {sleep, leds third..first}, expected {out, oe_n, pulldown, seq}, mask.
    logic [31:0] steps [15] = '{32'h0005009f, 32'h0004001f, 32'h0044109f, 32'h0044001f,
        32'h0144209f, 32'h0144101f, 32'h0244409f, 32'h0025004f, 32'h0024000f, 32'h0085009f,
        32'h0085801f, 32'h0005809f, 32'h00080067, 32'h00000047, 32'h0105009f};

    // A 40 ns clock.
    always #20 core_clk = ~core_clk;

    gcfg_top #(.ADDR_W(12)) uut (.core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .otp_default, .sleep_state, .led_driver_first,
        .led_driver_second, .led_driver_third, .pad_in, .pad_out, .pad_oe_n, .pad_pulldown,
        .pad_seq_assigned);

    gcfg_board board (.pad_out, .pad_oe_n, .pad_pulldown, .ext_en, .ext_val, .pad_in);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    function automatic logic [11:0] addr(input int i);
        return 12'({PIN_IDX[8*i +: 8], 2'b00});
    endfunction : addr

    // Handshakes are judged at the falling edge, since readies only move on rising edges.
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic aw_go, w_go, b_go;
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge core_clk);
            aw_go = s_axi_awvalid & s_axi_awready;
            w_go = s_axi_wvalid & s_axi_wready;
            b_go = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge core_clk);
            s_axi_awvalid <= s_axi_awvalid & ~aw_go;
            s_axi_wvalid <= s_axi_wvalid & ~w_go;
        end while (b_go !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd_reg(input logic [11:0] a);
        logic ar_go, r_go;
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge core_clk);
            ar_go = s_axi_arvalid & s_axi_arready;
            r_go = s_axi_rvalid;
            rd = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge core_clk);
            s_axi_arvalid <= s_axi_arvalid & ~ar_go;
        end while (r_go !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask : rd_reg

    // Pad outputs lag their cause by one cycle, so two falling edges are allowed.
    task automatic pins(input int i, input logic [3:0] exp, input logic [3:0] m);
        repeat (2) @(negedge core_clk);
        chk({28'h0, m & {pad_out[i], pad_oe_n[i], pad_pulldown[i], pad_seq_assigned[i]}}, {28'h0, exp});
    endtask : pins

    task automatic print_verdict();
        $display("checks %0d errors %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // Main sequence; the level bit is masked while it may still be unsettled.
    initial begin
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        for (int i = 0; i < NPIN; i++) begin
            rd_reg(addr(i));
            chk(rd & 32'hffff_fffd, {24'h0, otp_default[8*i +: 8] & WR_MASK});
        end
        pins(1, 4'hb, 4'hf);
        pins(0, 4'h4, 4'h7);
        foreach (steps[k]) begin
            @(posedge core_clk) {sleep_state, led_driver_third, led_driver_second, led_driver_first} <= steps[k][15:12];
            wr(addr(int'(steps[k][25:24])), {24'h0, steps[k][23:16]});
            pins(int'(steps[k][25:24]), steps[k][7:4], steps[k][3:0]);
        end
        wr(addr(0), 32'hffff_ffff);
        rd_reg(addr(0));
        chk(rd & 32'hffff_fffd, 32'h0000_00fd);
        chk({30'h0, rsp}, {30'h0, RESP_OKAY});
        wr(12'h118, 32'h0000_00ff);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        rd_reg(12'h118);
        chk(rd, 32'h0);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        // The fifth pin as an input: short debounce falling, then long debounce rising.
        wr(addr(2), 32'h0);
        repeat (2400) @(posedge core_clk);
        rd_reg(addr(2));
        chk(rd & 32'h2, 32'h2);
        @(posedge core_clk) ext_en <= 3'h4;
        repeat (2000) @(posedge core_clk);
        rd_reg(addr(2));
        chk(rd & 32'h2, 32'h2);
        repeat (400) @(posedge core_clk);
        rd_reg(addr(2));
        chk(rd & 32'h2, 32'h0);
        wr(addr(2), 32'h10);
        @(posedge core_clk) ext_val <= 3'h4;
        repeat (3000) @(posedge core_clk);
        rd_reg(addr(2));
        chk(rd & 32'h2, 32'h0);
        repeat (1000) @(posedge core_clk);
        rd_reg(addr(2));
        chk(rd & 32'h2, 32'h2);
        rd_reg(addr(1));
        chk(rd & 32'h2, 32'h2);
        // A second reset in mid-run must reload the new defaults.
        @(posedge core_clk) otp_default <= 24'h000035;
        @(posedge core_clk) rstn <= 1'b0;
        repeat (16) @(posedge core_clk);
        rstn <= 1'b1;
        rd_reg(addr(0));
        chk(rd & 32'hffff_fffd, 32'h0000_0035);
        print_verdict();
    end

    // The tests need about 9000 cycles; a hang is cut off well beyond that.
    initial begin
        repeat (40000) @(posedge core_clk);
        num_errors++;
        print_verdict();
    end
endmodule : pmic_gpio_pin_config_test
`default_nettype wire
